// ===== src/tps_sequencer.sv
// Purpose: three-rail power sequencer, up 1-2-3 and down 3-2-1
// Assumes: enable and polarity are pins; tick from local timebase
// Notes: outputs are open-drain style, enable low means pull low
`timescale 1ns/100ps
module tps_sequencer import tps_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_flag_polarity_select,
  input wire logic [7:0] i_timing_capacitance,
  output logic o_rail_one_release,
  output logic o_rail_two_release,
  output logic o_rail_three_release,
  output logic o_rail_one_release_oe_n,
  output logic o_rail_two_release_oe_n,
  output logic o_rail_three_release_oe_n,
  output logic o_tick
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic en_meta; // first stage, read only by en_sync
  logic en_sync;
  logic pol_meta;
  logic pol_sync;
  logic tick; // timebase strobe
  // Two flops on each pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      pol_meta <= 1'b0;
      pol_sync <= 1'b0;
    end else begin
      en_meta <= i_enable;
      en_sync <= en_meta;
      pol_meta <= i_flag_polarity_select;
      pol_sync <= pol_meta;
    end
  end
  // ==========================================================
  // Timebase
  // ==========================================================
  tps_timebase u_tps_timebase (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_cap_nf(i_timing_capacitance),
    .o_tick(tick)
  );
  // ==========================================================
  // Sequencer state machine
  // ==========================================================
  tps_state_e state; // current step
  tps_state_e next_state;
  logic [3:0] cnt; // ticks still to wait
  logic [3:0] next_cnt;
  logic [2:0] rel; // released flags, bit 0 is rail one
  logic [2:0] next_rel;
  // Next state, count and flags
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rel = rel;
    unique case (state)
      // Waiting for enable, flags held inactive
      TPS_IDLE: begin
        if (en_sync) begin
          next_state = TPS_UP1;
          next_cnt = TPS_FIRST_TICKS;
        end
      end
      // First step; partial tick plus 8 full ones gives 8 to 9
      TPS_UP1: begin
        if (!en_sync) begin
          next_state = TPS_IDLE;
          next_cnt = TPS_CNT_ZERO;
        end else if (tick) begin
          if (cnt == TPS_CNT_ONE) begin
            next_rel = 3'b001;
            next_state = TPS_UP2;
            next_cnt = TPS_LATER_TICKS;
          end else begin
            next_cnt = cnt - TPS_CNT_ONE;
          end
        end
      end
      // Second and third steps, 8 ticks each
      TPS_UP2, TPS_UP3: begin
        if (!en_sync) begin
          next_state = (state == TPS_UP2) ? TPS_DN1 : TPS_DN2;
          next_cnt = TPS_FIRST_TICKS;
        end else if (tick) begin
          if (cnt == TPS_CNT_ONE) begin
            next_rel = (state == TPS_UP2) ? 3'b011 : 3'b111;
            next_state = (state == TPS_UP2) ? TPS_UP3 : TPS_ON;
            next_cnt = TPS_LATER_TICKS;
          end else begin
            next_cnt = cnt - TPS_CNT_ONE;
          end
        end
      end
      // All rails up
      TPS_ON: begin
        if (!en_sync) begin
          next_state = TPS_DN3;
          next_cnt = TPS_FIRST_TICKS;
        end
      end
      // Power-down; runs to completion once begun
      TPS_DN3, TPS_DN2, TPS_DN1: begin
        if (tick) begin
          if (cnt == TPS_CNT_ONE) begin
            next_cnt = TPS_LATER_TICKS;
            if (state == TPS_DN3) begin
              next_rel = 3'b011;
              next_state = TPS_DN2;
            end else if (state == TPS_DN2) begin
              next_rel = 3'b001;
              next_state = TPS_DN1;
            end else begin
              next_rel = 3'b000;
              next_state = TPS_IDLE;
              next_cnt = TPS_CNT_ZERO;
            end
          end else begin
            next_cnt = cnt - TPS_CNT_ONE;
          end
        end
      end
    endcase
  end
  // Register sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= TPS_IDLE;
      cnt <= TPS_CNT_ZERO;
      rel <= 3'b000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rel <= next_rel;
    end
  end
  // ==========================================================
  // Output stage
  // ==========================================================
  logic [2:0] lvl; // logic level of each flag
  logic [2:0] next_lvl;
  // Polarity applied to released set
  always_comb begin
    next_lvl = next_rel ^ {3{pol_sync}};
  end
  // Register outputs; drain on when level is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lvl <= 3'b000;
      o_tick <= 1'b0;
    end else begin
      lvl <= next_lvl;
      o_tick <= tick;
    end
  end
  assign o_rail_one_release = 1'b0;
  assign o_rail_two_release = 1'b0;
  assign o_rail_three_release = 1'b0;
  assign o_rail_one_release_oe_n = lvl[0];
  assign o_rail_two_release_oe_n = lvl[1];
  assign o_rail_three_release_oe_n = lvl[2];
  // ==========================================================
  // Check helper: ticks seen in the current step
  // ==========================================================
  logic [3:0] step_ticks; // ticks since the last state change, saturating
  logic [3:0] next_step_ticks;
  // Restart on each step change, hold at all ones
  always_comb begin
    next_step_ticks = step_ticks;
    if (next_state != state) begin
      next_step_ticks = TPS_CNT_ZERO;
    end else if (tick && step_ticks != ~TPS_CNT_ZERO) begin
      next_step_ticks = step_ticks + TPS_CNT_ONE;
    end
  end
  // Register helper count
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      step_ticks <= TPS_CNT_ZERO;
    end else begin
      step_ticks <= next_step_ticks;
    end
  end
  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_idle_low: assert property (state == TPS_IDLE |-> rel == 3'b000)
    else $error("flags released while idle");
  a_order_up: assert property (rel != 3'b000 |-> rel[0])
    else $error("flag released out of order");
  a_order_mid: assert property (rel[2] |-> rel[1])
    else $error("third released before second");
  a_first_delay: assert property ($rose(rel[0]) |->
    $past(tick) && $past(step_ticks) == TPS_FIRST_TICKS - TPS_CNT_ONE)
    else $error("first flag after wrong tick count");
  a_second_delay: assert property ($rose(rel[1]) |->
    $past(tick) && $past(step_ticks) == TPS_LATER_TICKS - TPS_CNT_ONE)
    else $error("second flag after wrong tick count");
  a_third_delay: assert property ($rose(rel[2]) |->
    $past(tick) && $past(step_ticks) == TPS_LATER_TICKS - TPS_CNT_ONE)
    else $error("third flag after wrong tick count");
  a_down_first: assert property ($fell(rel[2]) |->
    $past(tick) && $past(step_ticks) == TPS_FIRST_TICKS - TPS_CNT_ONE)
    else $error("third flag dropped after wrong tick count");
  a_third_after: assert property ($rose(rel[2]) |-> $past(state) == TPS_UP3)
    else $error("third flag from wrong step");
  a_down_start: assert property (state == TPS_ON && !en_sync |=> state == TPS_DN3)
    else $error("power-down did not start");
  a_down_order: assert property ($fell(rel[1]) |-> !rel[2] && rel[0])
    else $error("power-down out of order");
  a_early_abort: assert property (state == TPS_UP1 && !en_sync |=> state == TPS_IDLE && rel == 3'b000)
    else $error("early disable not abandoned");
  a_mid_abort: assert property (state == TPS_UP3 && !en_sync |=> state == TPS_DN2 && rel == 3'b011)
    else $error("mid disable not reversed");
  a_polarity: assert property (lvl == ($past(rel) ^ {3{$past(pol_sync)}}) || $changed(rel))
    else $error("polarity not applied");
  c_full_up: cover property (state == TPS_UP3 ##1 state == TPS_ON);
  c_full_down: cover property (state == TPS_DN1 ##1 state == TPS_IDLE);
  c_abort: cover property (state == TPS_UP1 ##1 state == TPS_IDLE);
  c_inverted: cover property (pol_sync && rel == 3'b111);
endmodule

// ===== src/tps_pkg.sv
// Purpose: constants for the three-rail power sequencer
// Assumes: one 50 MHz clock, timebase arrives as a one-cycle tick strobe
// Notes: step delays are counted in timebase ticks
//
// Functional notes
// - Flags stay inactive until enable asserts; with polarity high, reset holds all pins low (active) until pol_sync settles
// - Release flags in order one, two, three
// - First release after 8 to 9 ticks
// - Second release exactly 8 ticks later
// - Third release another 8 ticks later
// - On disable, drop third flag after delay
// - Then second, then first; same delays
// - Polarity input inverts all three flags
// - Tick period scales with timing capacitance
// - Polarity low active high; high active low
// - Early disable abandons count, flags unchanged
// - Disable mid power-up reverses released flags
package tps_pkg;
  // ==========================================================
  // Step timing in ticks
  // ==========================================================
  localparam logic [3:0] TPS_FIRST_TICKS = 4'h9; // first step, one extra for the partial tick
  localparam logic [3:0] TPS_LATER_TICKS = 4'h8; // every later step
  localparam logic [3:0] TPS_CNT_ZERO = 4'h0;
  localparam logic [3:0] TPS_CNT_ONE = 4'h1;
  // Tick scale: 120 us per nF of timing capacitance
  localparam int TPS_TICK_NS_PER_NF = 120000;
  localparam int TPS_CLK_PERIOD_NS = 20;
  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    TPS_IDLE = 3'b000,
    TPS_UP1 = 3'b001,
    TPS_UP2 = 3'b010,
    TPS_UP3 = 3'b011,
    TPS_ON = 3'b100,
    TPS_DN3 = 3'b101,
    TPS_DN2 = 3'b110,
    TPS_DN1 = 3'b111
  } tps_state_e;
endpackage

// ===== src/tps_timebase.sv
// Purpose: timebase that stands in for the capacitor oscillator
// Assumes: capacitance given in nF as a port level, held steady
// Notes: one-cycle tick pulse every capacitance times 120 us
`timescale 1ns/100ps
module tps_timebase import tps_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_cap_nf,
  output logic o_tick
);
  // ==========================================================
  // Period divider
  // ==========================================================
  localparam int CYC_PER_NF = TPS_TICK_NS_PER_NF / TPS_CLK_PERIOD_NS;
  logic [31:0] count; // cycles since last tick
  logic [31:0] next_count;
  logic next_tick;
  logic [31:0] period; // cycles per tick, at least one
  // Period from capacitance
  always_comb begin
    period = 32'(i_cap_nf) * 32'(CYC_PER_NF);
    if (period == 32'h0) begin
      period = 32'h1;
    end
    next_tick = 1'b0;
    next_count = count + 32'h1;
    if (next_count >= period) begin
      next_count = 32'h0;
      next_tick = 1'b1;
    end
  end
  // Register divider
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count <= 32'h0;
      o_tick <= 1'b0;
    end else begin
      count <= next_count;
      o_tick <= next_tick;
    end
  end
endmodule

// ===== verif/tps_rail_model.sv
// Purpose: regulator enable inputs behind the three flag pins
// Assumes: each open-drain pin has its own pull-up
// Notes: a rail runs when its pin shows the active level
`timescale 1ns/100ps
module tps_rail_model (
  input wire logic [2:0] i_release,
  input wire logic [2:0] i_oe_n,
  input wire logic i_pol,
  output logic [2:0] o_pin,
  output logic [2:0] o_rail_on
);
  // ====================
  // Pin level
  // ====================
  // Released pin floats up to one
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_pin[k] = i_oe_n[k] ? 1'b1 : i_release[k];
    end
  end
  // Enable sense follows the polarity tie
  assign o_rail_on = o_pin ^ {3{i_pol}};
endmodule

// ===== verif/tps_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: capacitance 0 (one tick every clock) except in the tick test
// Notes: notes hold expected pin levels and gap ranges
`timescale 1ns/100ps
module tps_sequencer_tb;
  typedef struct {logic [2:0] pin; int lo; int hi;} tps_note_s;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_enable = 1'b0;
  logic pol = 1'b0;
  wire [2:0] rel, oe_n, pin, rail_on;
  wire tick;
  logic [2:0] last = 3'h0;
  logic [7:0] cap = 8'h00;
  logic [31:0] seed = 32'h3a3a5ee6;
  tps_note_s notes[$];
  int cyc = 0, mark = 0, n_mismatch = 0, cmp_count = 0, gap = 0;
  always #10 i_clock = ~i_clock;
  tps_sequencer u_tps_sequencer (.i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable),
    .i_flag_polarity_select(pol), .i_timing_capacitance(cap),
    .o_rail_one_release(rel[0]), .o_rail_two_release(rel[1]), .o_rail_three_release(rel[2]),
    .o_rail_one_release_oe_n(oe_n[0]), .o_rail_two_release_oe_n(oe_n[1]),
    .o_rail_three_release_oe_n(oe_n[2]), .o_tick(tick));
  tps_rail_model u_tps_rail_model (.i_release(rel), .i_oe_n(oe_n), .i_pol(pol),
    .o_pin(pin), .o_rail_on(rail_on));
  // ====================
  // Helpers
  // ====================
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Expected pins from rail state and current polarity
  task automatic note(input logic [2:0] on, input int lo, input int hi);
    tps_note_s n;
    n.pin = on ^ {3{pol}};
    n.lo = lo;
    n.hi = hi;
    notes.push_back(n);
  endtask
  task automatic set_en(input logic v);
    @(negedge i_clock);
    i_enable = v;
    mark = cyc;
  endtask
  // Bounded wait until every note is used
  task automatic drain;
    for (int k = 0; k < 200 && notes.size() != 0; k++) begin
      @(negedge i_clock);
    end
    chk(notes.size(), 0);
  endtask
  task automatic give_verdict;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ====================
  // Monitor: each pin change takes the oldest note
  // ====================
  always @(posedge i_clock) begin
    tps_note_s n;
    #1;
    cyc++;
    if (pin !== last) begin
      if (notes.size() == 0) begin
        chk({29'h0, pin}, {29'h0, last});
      end else begin
        n = notes.pop_front();
        chk({29'h0, pin}, {29'h0, n.pin});
        chk({31'h0, cyc - mark >= n.lo && cyc - mark <= n.hi}, 32'h1);
      end
      last = pin;
      mark = cyc;
    end
  end
  // Watchdog well past the expected run
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
  // ====================
  // Main sequence
  // ====================
  initial begin
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (20) @(negedge i_clock);
    chk({29'h0, pin}, 32'h0);
    chk({31'h0, tick}, 32'h1);
    $display("test idle done");
    // Tick spacing follows the timing capacitance
    cap = 8'h01;
    repeat (2) @(negedge i_clock);
    for (int k = 0; k < 7000 && tick !== 1'b1; k++) begin
      @(negedge i_clock);
    end
    gap = 0;
    do begin
      @(negedge i_clock);
      gap++;
    end while (gap < 7000 && tick !== 1'b1);
    chk(gap, tps_pkg::TPS_TICK_NS_PER_NF / tps_pkg::TPS_CLK_PERIOD_NS);
    cap = 8'h00;
    repeat (3) @(negedge i_clock);
    chk({31'h0, tick}, 32'h1);
    $display("test tick done");
    // Full up and down, both polarities
    for (int p = 0; p < 3; p++) begin
      @(negedge i_clock);
      pol = p[0];
      mark = cyc;
      if (p != 0) begin
        note(3'h0, 3, 3);
        drain;
      end
      if (p == 2) break;
      note(3'h1, 12, 13);
      note(3'h3, 8, 8);
      note(3'h7, 8, 8);
      set_en(1'b1);
      drain;
      chk({29'h0, rail_on}, 32'h7);
      note(3'h3, 12, 13);
      note(3'h1, 8, 8);
      note(3'h0, 8, 8);
      set_en(1'b0);
      drain;
      $display("test sequence done pol=%0d", p);
    end
    // Short random enable pulses change nothing
    for (int g = 0; g < 4; g++) begin
      seed = xs(seed);
      set_en(1'b1);
      repeat (1 + int'(seed % 6)) @(negedge i_clock);
      i_enable = 1'b0;
      repeat (30) @(negedge i_clock);
    end
    $display("test glitch done");
    // Drop after rail one, then after rail two
    for (int s = 1; s < 3; s++) begin
      note(3'h1, 12, 13);
      if (s == 2) note(3'h3, 8, 8);
      set_en(1'b1);
      drain;
      note((s == 2) ? 3'h1 : 3'h0, 12, 13);
      if (s == 2) note(3'h0, 8, 8);
      set_en(1'b0);
      drain;
    end
    $display("test partial done");
    // Reset in mid-sequence clears every flag
    note(3'h1, 12, 13);
    set_en(1'b1);
    drain;
    note(3'h0, 1, 1);
    @(negedge i_clock);
    i_enable = 1'b0;
    i_rst = 1'b1;
    mark = cyc;
    drain;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (20) @(negedge i_clock);
    chk({29'h0, pin}, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule
